/* include/ppfm_pkg.sv */
// Purpose: shared constants for the port pin function mux
// Assumes: one clock, synchronous active-low reset
// Notes: pin index 0..5 is port 1 bits 2..7, 6..11 is port 2 bits 0..5
// Behaviour
// R1 - LCD-shared pins are port only when unselected
// R2 - P1.2-P1.5 become S31-S28 at mode E0h
// R3 - P1.6-P1.7 become S27-S26 at mode C0h
// R4 - P2.0-P2.1 become S25-S24 at mode E0h
// R5 - P1.2 drives compare out 1, feeds capture 1A
// R6 - P1.7 is slave-out line, serial direction
// R7 - P2.1 is serial clock, serial direction
// R8 - P2.2 input only, feeds slave transmit enable
// R9 - P2.4 output only, drives uart transmit
// R10 - P2.5 input only, feeds uart receive
// R11 - P2.2-P2.5 port only while buffer enabled
// R12 - P2.3 loses port when level select 1111b
// R13 - P2.6-P2.7 keep full register bits, no pins
// R14 - P2.6-P2.7 flags change by software only
// R15 - select field thresholds 05h and 04h
// R16 - unselected pin uses port output and direction
// R17 - edge sets flag, enable gates the request
package ppfm_pkg;
	localparam int         NPIN    = 12;
	localparam int         PIN_P1_2 = 0;
	localparam int         PIN_P1_3 = 1;
	localparam int         PIN_P1_4 = 2;
	localparam int         PIN_P1_5 = 3;
	localparam int         PIN_P1_6 = 4;
	localparam int         PIN_P1_7 = 5;
	localparam int         PIN_P2_0 = 6;
	localparam int         PIN_P2_1 = 7;
	localparam int         PIN_P2_2 = 8;
	localparam int         PIN_P2_3 = 9;
	localparam int         PIN_P2_4 = 10;
	localparam int         PIN_P2_5 = 11;
	localparam int         NLCDPIN  = 8;
	localparam int         MODE_W   = 8;
	localparam int         SEGSEL_W = 4;
	localparam int         LEVEL_W  = 4;
	localparam logic [7:0] MODE_THR_A = 8'hE0;
	localparam logic [7:0] MODE_THR_B = 8'hC0;
	localparam logic [7:0] MODE_THR_C = 8'hE0;
	localparam logic [3:0] SEGSEL_THR_A = 4'h5;
	localparam logic [3:0] SEGSEL_THR_B = 4'h4;
	localparam logic [3:0] LEVEL_EXT_INPUT = 4'hF;
	localparam logic [11:0] RST_PINS = 12'h000;
	localparam logic [7:0]  RST_BYTE = 8'h00;

	// Threshold group a LCD-shared pin belongs to
	typedef enum logic [1:0] {
		GRP_A = 2'b00,
		GRP_B = 2'b01,
		GRP_C = 2'b10
	} ppfm_lcd_grp_t;
endpackage : ppfm_pkg

/* rtl/ppfm_irq_bank.sv */
// Purpose: edge detect and interrupt flags for one 8-bit port
// Assumes: level already registered and gated by port activity
// Notes: request output is combinational from flags and enables
`timescale 1ns/1ns
module ppfm_irq_bank (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic [7:0] level,
	input  wire logic [7:0] edge_en,
	input  wire logic [7:0] edge_sel,
	input  wire logic [7:0] irq_en,
	input  wire logic       flag_wr,
	input  wire logic [7:0] flag_wdata,
	output logic      [7:0] flag,
	output logic            irq
);
	import ppfm_pkg::*;

	logic [7:0] prev;
	logic [7:0] hit;

	// Previous level for edge compare
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prev <= RST_BYTE;
		end else begin
			prev <= level;
		end
	end

	// R17 - rising when select low, falling when high
	assign hit = edge_en & ((~edge_sel & level & ~prev) | (edge_sel & ~level & prev));

	// R17 - set wins over a same-cycle software clear
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			flag <= RST_BYTE;
		end else begin
			flag <= (flag_wr ? flag_wdata : flag) | hit;
		end
	end

	// R17 - enable gates the request
	assign irq = |(flag & irq_en);
endmodule : ppfm_irq_bank

/* rtl/ppfm_top.sv */
// Purpose: pin function mux for port 1 bits 2-7 and port 2 bits 0-5
// Assumes: all inputs synchronous to sys_clk
// Notes: pin drive, enables and peripheral inputs lag one cycle
`timescale 1ns/1ns
module ppfm_top (
	input  wire logic                           sys_clk,
	input  wire logic                           nrst,
	input  wire logic [7:2]                     p1_peripheral_select_bit,
	input  wire logic [7:2]                     p1_pin_direction_bit,
	input  wire logic [7:2]                     p1_pin_output_bit,
	input  wire logic [7:2]                     p1_pin_irq_enable_bit,
	input  wire logic [7:2]                     p1_pin_irq_edge_select_bit,
	input  wire logic                           p1_flag_write,
	input  wire logic [7:2]                     p1_flag_wdata,
	input  wire logic [7:0]                     p2_peripheral_select_bit,
	input  wire logic [7:0]                     p2_pin_direction_bit,
	input  wire logic [7:0]                     p2_pin_output_bit,
	input  wire logic [7:0]                     p2_pin_irq_enable_bit,
	input  wire logic [7:0]                     p2_pin_irq_edge_select_bit,
	input  wire logic                           p2_flag_write,
	input  wire logic [7:0]                     p2_flag_wdata,
	input  wire logic [5:2]                     input_buffer_disable_bit,
	input  wire logic [ppfm_pkg::LEVEL_W-1:0]   voltage_level_select,
	input  wire logic [ppfm_pkg::MODE_W-1:0]    lcd_mode_field,
	input  wire logic [ppfm_pkg::SEGSEL_W-1:0]  lcd_port_segment_select,
	input  wire logic                           lcd_corrected_thresholds,
	input  wire logic                           timer_compare_out_1,
	input  wire logic                           timer_compare_out_2,
	input  wire logic                           supervisor_flag_output,
	input  wire logic                           aux_clock_out,
	input  wire logic                           serial_master_out_line_o,
	input  wire logic                           serial_slave_out_line_o,
	input  wire logic                           serial_clock_line_o,
	input  wire logic                           uart_transmit_line,
	input  wire logic                           master_out_dir_control,
	input  wire logic                           slave_out_dir_control,
	input  wire logic                           serial_clock_dir_control,
	input  wire logic [ppfm_pkg::NPIN-1:0]      pin_in,
	output logic      [ppfm_pkg::NPIN-1:0]      pin_out,
	output logic      [ppfm_pkg::NPIN-1:0]      pin_oe,
	output logic      [ppfm_pkg::NLCDPIN-1:0]   lcd_segment_enable,
	output logic      [7:2]                     p1_pin_input_bit,
	output logic      [7:0]                     p2_pin_input_bit,
	output logic      [7:2]                     p1_pin_irq_flag_bit,
	output logic      [7:0]                     p2_pin_irq_flag_bit,
	output logic                                p1_irq,
	output logic                                p2_irq,
	output logic                                timer_capture_in_1a,
	output logic                                timer_capture_in_2a,
	output logic                                timer_external_clock_in,
	output logic                                serial_master_out_line_i,
	output logic                                serial_slave_out_line_i,
	output logic                                serial_clock_line_i,
	output logic                                serial_slave_tx_enable,
	output logic                                uart_receive_line
);
	import ppfm_pkg::*;

	logic [NPIN-1:0]    sel;
	logic [NPIN-1:0]    dir;
	logic [NPIN-1:0]    pout;
	logic [NPIN-1:0]    mout;
	logic [NPIN-1:0]    mdir;
	logic [NPIN-1:0]    act;
	logic [NPIN-1:0]    pe;
	logic [NPIN-1:0]    in_q;
	logic [NPIN-1:0]    act_q;
	logic [NLCDPIN-1:0] lcd;
	logic [7:0]         p1_flag_all;

	// Segment threshold decode, mode field or port-segment select
	function automatic logic lcd_on(
		input ppfm_lcd_grp_t       g,
		input logic                corr,
		input logic [MODE_W-1:0]   mode,
		input logic [SEGSEL_W-1:0] seg
	);
		lcd_on = 1'b0;
		unique case (g)
			GRP_A: lcd_on = corr ? (seg >= SEGSEL_THR_A) : (mode >= MODE_THR_A);
			GRP_B: lcd_on = corr ? (seg >= SEGSEL_THR_B) : (mode >= MODE_THR_B);
			GRP_C: lcd_on = corr ? (seg >= SEGSEL_THR_B) : (mode >= MODE_THR_C);
			default: lcd_on = 1'b0;
		endcase
	endfunction : lcd_on

	// Pin index to threshold group
	function automatic ppfm_lcd_grp_t grp_of(input int k);
		grp_of = GRP_C;
		if (k <= PIN_P1_5) begin
			grp_of = GRP_A;
		end else if (k <= PIN_P1_7) begin
			grp_of = GRP_B;
		end
	endfunction : grp_of

	// Flatten both ports into one pin-indexed view
	assign sel  = {p2_peripheral_select_bit[5:0], p1_peripheral_select_bit};
	assign dir  = {p2_pin_direction_bit[5:0], p1_pin_direction_bit};
	assign pout = {p2_pin_output_bit[5:0], p1_pin_output_bit};

	// Peripheral output per pin, unused ones stay low
	always_comb begin
		mout = RST_PINS;
		// R5 - compare out 1
		mout[PIN_P1_2] = timer_compare_out_1;
		mout[PIN_P1_3] = supervisor_flag_output;
		mout[PIN_P1_5] = aux_clock_out;
		mout[PIN_P1_6] = serial_master_out_line_o;
		// R6 - slave-out drive
		mout[PIN_P1_7] = serial_slave_out_line_o;
		mout[PIN_P2_0] = timer_compare_out_2;
		// R7 - serial clock drive
		mout[PIN_P2_1] = serial_clock_line_o;
		// R9 - uart transmit drive
		mout[PIN_P2_4] = uart_transmit_line;
	end

	// Direction seen when the peripheral owns the pin
	always_comb begin
		mdir = dir;
		mdir[PIN_P1_6] = master_out_dir_control;
		// R6 - serial direction control
		mdir[PIN_P1_7] = slave_out_dir_control;
		// R7 - clock direction control
		mdir[PIN_P2_1] = serial_clock_dir_control;
		// R8 - forced input
		mdir[PIN_P2_2] = 1'b0;
		// R9 - forced output
		mdir[PIN_P2_4] = 1'b1;
		// R10 - forced input
		mdir[PIN_P2_5] = 1'b0;
	end

	// Port function activity per pin
	always_comb begin
		lcd = RST_BYTE;
		// R2 R3 R4 R15 - group thresholds
		for (int k = 0; k < NLCDPIN; k++) begin
			lcd[k] = lcd_on(grp_of(k), lcd_corrected_thresholds,
					lcd_mode_field, lcd_port_segment_select);
		end
		act = RST_PINS;
		// R1 - port only while not a segment
		act[NLCDPIN-1:0] = ~lcd;
		// R11 - input buffer disable
		act[PIN_P2_2] = ~input_buffer_disable_bit[2];
		// R12 - supervisor analog input
		act[PIN_P2_3] = ~input_buffer_disable_bit[3] &
				(voltage_level_select != LEVEL_EXT_INPUT);
		act[PIN_P2_4] = ~input_buffer_disable_bit[4];
		act[PIN_P2_5] = ~input_buffer_disable_bit[5];
	end

	// Input seen by a selected peripheral
	assign pe = pin_in & act & sel;

	// Pin drive; an inactive pin is never driven
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pin_out <= RST_PINS;
			pin_oe  <= RST_PINS;
		end else begin
			// R16 - port bits unless selected
			pin_out <= (sel & mout) | (~sel & pout);
			pin_oe  <= act & ((sel & mdir) | (~sel & dir));
		end
	end

	// Input sampling, gated so a disabled buffer reads low
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			in_q  <= RST_PINS;
			act_q <= RST_PINS;
		end else begin
			in_q  <= pin_in & act;
			act_q <= act;
		end
	end

	// Segment enables, bit k is segment 24+k
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			lcd_segment_enable <= RST_BYTE;
		end else begin
			for (int k = 0; k < NLCDPIN; k++) begin
				lcd_segment_enable[NLCDPIN-1-k] <= lcd[k];
			end
		end
	end

	// Peripheral inputs, low while not selected
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			timer_capture_in_1a      <= 1'b0;
			timer_capture_in_2a      <= 1'b0;
			timer_external_clock_in  <= 1'b0;
			serial_master_out_line_i <= 1'b0;
			serial_slave_out_line_i  <= 1'b0;
			serial_clock_line_i      <= 1'b0;
			serial_slave_tx_enable   <= 1'b0;
			uart_receive_line        <= 1'b0;
		end else begin
			// R5 - capture 1A feed
			timer_capture_in_1a      <= pe[PIN_P1_2];
			timer_capture_in_2a      <= pe[PIN_P2_0];
			timer_external_clock_in  <= pe[PIN_P1_5];
			serial_master_out_line_i <= pe[PIN_P1_6];
			// R6 - slave-out receive
			serial_slave_out_line_i  <= pe[PIN_P1_7];
			// R7 - serial clock receive
			serial_clock_line_i      <= pe[PIN_P2_1];
			// R8 - slave transmit enable feed
			serial_slave_tx_enable   <= pe[PIN_P2_2];
			// R10 - uart receive feed
			uart_receive_line        <= pe[PIN_P2_5];
		end
	end

	// Input bits; unbonded bits have nothing to read
	assign p1_pin_input_bit = in_q[PIN_P1_7:PIN_P1_2];
	assign p2_pin_input_bit = {2'b00, in_q[PIN_P2_5:PIN_P2_0]};

	// Port 1 flags; bits 1:0 live elsewhere and are padded off
	ppfm_irq_bank u_p1_irq (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.level      ({in_q[PIN_P1_7:PIN_P1_2], 2'b00}),
		.edge_en    ({act_q[PIN_P1_7:PIN_P1_2], 2'b00}),
		.edge_sel   ({p1_pin_irq_edge_select_bit, 2'b00}),
		.irq_en     ({p1_pin_irq_enable_bit, 2'b00}),
		.flag_wr    (p1_flag_write),
		.flag_wdata ({p1_flag_wdata, 2'b00}),
		.flag       (p1_flag_all),
		.irq        (p1_irq)
	);
	assign p1_pin_irq_flag_bit = p1_flag_all[7:2];

	// Port 2 flags; R13 R14 - bits 7:6 kept but never edge-set
	ppfm_irq_bank u_p2_irq (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.level      ({2'b00, in_q[PIN_P2_5:PIN_P2_0]}),
		.edge_en    ({2'b00, act_q[PIN_P2_5:PIN_P2_0]}),
		.edge_sel   (p2_pin_irq_edge_select_bit),
		.irq_en     (p2_pin_irq_enable_bit),
		.flag_wr    (p2_flag_write),
		.flag_wdata (p2_flag_wdata),
		.flag       (p2_pin_irq_flag_bit),
		.irq        (p2_irq)
	);

	// Checks on the registered pin view
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	chk_seg_pin_off: assert property ( // R1
		!act[PIN_P1_4] |=> !pin_oe[PIN_P1_4] && !p1_pin_input_bit[4])
		else $error("segment pin still acts as port");
	chk_mode_p1a: assert property ( // R2
		(!lcd_corrected_thresholds && lcd_mode_field >= 8'hE0)
		|=> lcd_segment_enable[7] && !pin_oe[PIN_P1_2])
		else $error("P1.2 not segment at mode E0h");
	chk_mode_p1b: assert property ( // R3
		(!lcd_corrected_thresholds && lcd_mode_field == 8'hDF)
		|=> lcd_segment_enable[3] && lcd_segment_enable[2] && !lcd_segment_enable[7])
		else $error("mode DFh threshold wrong");
	chk_mode_p2: assert property ( // R4
		(!lcd_corrected_thresholds && lcd_mode_field < 8'hE0)
		|=> !lcd_segment_enable[1] && !lcd_segment_enable[0])
		else $error("P2.0 segment below E0h");
	chk_cmp1_drive: assert property ( // R5
		(sel[PIN_P1_2] && act[PIN_P1_2])
		|=> pin_out[PIN_P1_2] == $past(timer_compare_out_1))
		else $error("P1.2 not driving compare out 1");
	chk_miso_dir: assert property ( // R6
		(sel[PIN_P1_7] && act[PIN_P1_7])
		|=> pin_oe[PIN_P1_7] == $past(slave_out_dir_control))
		else $error("P1.7 direction not from serial");
	chk_uclk_dir: assert property ( // R7
		(sel[PIN_P2_1] && act[PIN_P2_1])
		|=> pin_oe[PIN_P2_1] == $past(serial_clock_dir_control))
		else $error("P2.1 direction not from serial");
	chk_ste_input: assert property ( // R8
		sel[PIN_P2_2] |=> !pin_oe[PIN_P2_2] &&
		serial_slave_tx_enable == $past(pin_in[PIN_P2_2] & act[PIN_P2_2]))
		else $error("P2.2 not input to slave enable");
	chk_utx_output: assert property ( // R9
		(sel[PIN_P2_4] && !input_buffer_disable_bit[4])
		|=> pin_oe[PIN_P2_4] && pin_out[PIN_P2_4] == $past(uart_transmit_line))
		else $error("P2.4 not driving uart transmit");
	chk_urx_input: assert property ( // R10
		sel[PIN_P2_5] |=> !pin_oe[PIN_P2_5])
		else $error("P2.5 driven while receive");
	chk_bufdis_off: assert property ( // R11
		input_buffer_disable_bit[5] |=> !pin_oe[PIN_P2_5] && !p2_pin_input_bit[5])
		else $error("disabled buffer still active");
	chk_vld_analog: assert property ( // R12
		(voltage_level_select == 4'hF) |=> !pin_oe[PIN_P2_3] && !p2_pin_input_bit[3])
		else $error("P2.3 digital at level 1111b");
	chk_soft_flag_wr: assert property ( // R13
		p2_flag_write |=> p2_pin_irq_flag_bit[7:6] == $past(p2_flag_wdata[7:6]))
		else $error("unbonded flag write lost");
	chk_soft_flag_hold: assert property ( // R14
		!p2_flag_write |=> $stable(p2_pin_irq_flag_bit[7:6]))
		else $error("unbonded flag moved without write");
	chk_corr_thresh: assert property ( // R15
		(lcd_corrected_thresholds && lcd_port_segment_select == 4'h4)
		|=> !lcd_segment_enable[7] && lcd_segment_enable[1] && lcd_segment_enable[0])
		else $error("corrected threshold 04h wrong");
	chk_gpio_drive: assert property ( // R16
		!sel[PIN_P1_3] |=> pin_out[PIN_P1_3] == $past(p1_pin_output_bit[3]))
		else $error("unselected pin not from port bit");
	chk_edge_flag: assert property ( // R17
		($rose(p1_pin_input_bit[2]) && !p1_pin_irq_edge_select_bit[2])
		|=> p1_pin_irq_flag_bit[2])
		else $error("rising edge did not set flag");

	cov_spi_out: cover property (sel[PIN_P1_7] && slave_out_dir_control ##1 pin_oe[PIN_P1_7]);
	cov_lcd_swap: cover property (!lcd_segment_enable[7] ##1 lcd_segment_enable[7]);
	cov_soft_irq: cover property (p2_flag_write && p2_flag_wdata[7] ##1 p2_irq);
	cov_pin_irq: cover property ($rose(p1_irq));
endmodule : ppfm_top

/* tb/ppfm_pad_model.sv */
// Purpose: board side of the muxed pins, pads and external drivers
// Assumes: one clock, pads sampled by the mux on the rising edge
// Notes: undriven pads float and flip every cycle, never holding a stale level
`timescale 1ns/1ns
module ppfm_pad_model (
	input  wire logic        sys_clk,
	input  wire logic [11:0] pin_out,
	input  wire logic [11:0] pin_oe,
	input  wire logic [11:0] ext_drive,
	input  wire logic [11:0] ext_level,
	output logic      [11:0] pin_in
);
	logic [11:0] float_lvl = 12'h000;

	// Floating pattern moves off the edge so the mux never races it
	always @(posedge sys_clk) begin
		float_lvl <= #1 ~float_lvl;
	end

	// Device drive wins, then the board, else the pad floats
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_drive[i] ? ext_level[i] : float_lvl[i]);
		end
	end
endmodule : ppfm_pad_model

/* tb/tb.sv */
// Purpose: self-checking bench for the port pin function mux
// Assumes: registered outputs one cycle after inputs, combinational irq
// Notes: a cycle model is compared with every output on each falling edge
`timescale 1ns/1ns
module tb;
	logic        sys_clk, nrst, p1_flag_write, p2_flag_write, lcd_corrected_thresholds;
	logic        timer_compare_out_1, timer_compare_out_2, supervisor_flag_output, aux_clock_out;
	logic        serial_master_out_line_o, serial_slave_out_line_o, serial_clock_line_o;
	logic        uart_transmit_line, master_out_dir_control, slave_out_dir_control;
	logic        serial_clock_dir_control, p1_irq, p2_irq, timer_capture_in_1a;
	logic        timer_capture_in_2a, timer_external_clock_in, serial_master_out_line_i;
	logic        serial_slave_out_line_i, serial_clock_line_i, serial_slave_tx_enable;
	logic        uart_receive_line, live;
	logic [7:2]  p1_peripheral_select_bit, p1_pin_direction_bit, p1_pin_output_bit;
	logic [7:2]  p1_pin_irq_enable_bit, p1_pin_irq_edge_select_bit, p1_flag_wdata;
	logic [7:2]  p1_pin_input_bit, p1_pin_irq_flag_bit;
	logic [7:0]  p2_peripheral_select_bit, p2_pin_direction_bit, p2_pin_output_bit;
	logic [7:0]  p2_pin_irq_enable_bit, p2_pin_irq_edge_select_bit, p2_flag_wdata;
	logic [7:0]  p2_pin_input_bit, p2_pin_irq_flag_bit, lcd_mode_field, lcd_segment_enable;
	logic [5:2]  input_buffer_disable_bit;
	logic [3:0]  voltage_level_select, lcd_port_segment_select;
	logic [11:0] pin_in, pin_out, pin_oe, ext_drive, ext_level;
	logic [11:0] sel, dir, po, mo, md, act, pk, ex_oe, ex_out;
	logic [13:0] ies, wm, ev, ex_in, ex_prev, ex_a, ex_f;
	logic [7:0]  segv, thr, ex_seg, ex_per;
	logic [7:0]  mtab [4] = '{8'hBF, 8'hC0, 8'hDF, 8'hE0};
	logic [3:0]  ptab [4] = '{4'h3, 4'h4, 4'h5, 4'hF};
	int          err_total, total_checks, seed;

	ppfm_top u_ppfm_top (.sys_clk, .nrst, .p1_peripheral_select_bit, .p1_pin_direction_bit,
		.p1_pin_output_bit, .p1_pin_irq_enable_bit, .p1_pin_irq_edge_select_bit, .p1_flag_write,
		.p1_flag_wdata, .p2_peripheral_select_bit, .p2_pin_direction_bit, .p2_pin_output_bit,
		.p2_pin_irq_enable_bit, .p2_pin_irq_edge_select_bit, .p2_flag_write, .p2_flag_wdata,
		.input_buffer_disable_bit, .voltage_level_select, .lcd_mode_field,
		.lcd_port_segment_select, .lcd_corrected_thresholds, .timer_compare_out_1,
		.timer_compare_out_2, .supervisor_flag_output, .aux_clock_out, .serial_master_out_line_o,
		.serial_slave_out_line_o, .serial_clock_line_o, .uart_transmit_line,
		.master_out_dir_control, .slave_out_dir_control, .serial_clock_dir_control, .pin_in,
		.pin_out, .pin_oe, .lcd_segment_enable, .p1_pin_input_bit, .p2_pin_input_bit,
		.p1_pin_irq_flag_bit, .p2_pin_irq_flag_bit, .p1_irq, .p2_irq, .timer_capture_in_1a,
		.timer_capture_in_2a, .timer_external_clock_in, .serial_master_out_line_i,
		.serial_slave_out_line_i, .serial_clock_line_i, .serial_slave_tx_enable,
		.uart_receive_line);

	ppfm_pad_model u_ppfm_pad_model (.sys_clk, .pin_out, .pin_oe, .ext_drive, .ext_level,
		.pin_in);

	// Free-running 100 MHz clock
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Cycle model, sees the inputs as the design samples them
	always @(posedge sys_clk) begin
		live = 1'h1;
		sel = {p2_peripheral_select_bit[5:0], p1_peripheral_select_bit};
		dir = {p2_pin_direction_bit[5:0], p1_pin_direction_bit};
		po = {p2_pin_output_bit[5:0], p1_pin_output_bit};
		mo = {1'h0, uart_transmit_line, 2'h0, serial_clock_line_o, timer_compare_out_2,
			serial_slave_out_line_o, serial_master_out_line_o, aux_clock_out, 1'h0,
			supervisor_flag_output, timer_compare_out_1};
		md = {1'h0, 1'h1, dir[9], 1'h0, serial_clock_dir_control, dir[6],
			slave_out_dir_control, master_out_dir_control, dir[3:0]};
		for (int i = 0; i < 8; i++) begin
			if (lcd_corrected_thresholds) begin
				thr = (i < 4) ? 8'h05 : 8'h04;
			end else begin
				thr = (i == 4 || i == 5) ? 8'hC0 : 8'hE0;
			end
			segv[7 - i] = (lcd_corrected_thresholds ? {4'h0, lcd_port_segment_select}
				: lcd_mode_field) >= thr;
			act[i] = !segv[7 - i];
		end
		act[11:8] = ~input_buffer_disable_bit & {2'h3, voltage_level_select != 4'hF, 1'h1};
		ies = {p2_pin_irq_edge_select_bit, p1_pin_irq_edge_select_bit};
		wm = {{8{p2_flag_write}}, {6{p1_flag_write}}};
		ev = ex_a & ((ies & ex_prev & ~ex_in) | (~ies & ex_in & ~ex_prev));
		pk = pin_in & act & sel;
		if (!nrst) begin
			{ex_in, ex_prev, ex_a, ex_f, ex_oe, ex_out, ex_seg, ex_per} = '0;
		end else begin
			ex_f = (ex_f & ~wm) | ({p2_flag_wdata, p1_flag_wdata} & wm) | ev;
			ex_prev = ex_in;
			ex_in = 14'(pin_in & act);
			ex_a = 14'(act);
			ex_oe = act & ((sel & md) | (~sel & dir));
			ex_out = (sel & mo) | (~sel & po);
			ex_seg = segv;
			ex_per = {pk[0], pk[6], pk[3], pk[4], pk[5], pk[7], pk[8], pk[11]};
		end
	end

	task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Outputs settled by the falling edge, irq against live enables
	always @(negedge sys_clk) begin
		if (live) begin
			check("pin_oe", 14'(ex_oe), 14'(pin_oe));
			check("pin_out", 14'(ex_out), 14'(pin_out));
			check("segment", 14'(ex_seg), 14'(lcd_segment_enable));
			check("input_bit", ex_in, {p2_pin_input_bit, p1_pin_input_bit});
			check("periph_in", 14'(ex_per), 14'({timer_capture_in_1a, timer_capture_in_2a,
				timer_external_clock_in, serial_master_out_line_i, serial_slave_out_line_i,
				serial_clock_line_i, serial_slave_tx_enable, uart_receive_line}));
			check("flag", ex_f, {p2_pin_irq_flag_bit, p1_pin_irq_flag_bit});
			check("irq", 14'({|(ex_f[13:6] & p2_pin_irq_enable_bit),
				|(ex_f[5:0] & p1_pin_irq_enable_bit)}), 14'({p2_irq, p1_irq}));
		end
	end

	// Fresh random pad, port and peripheral traffic, rare flag writes
	task automatic rand_inputs();
		logic [127:0] r;
		r = {$urandom, $urandom, $urandom, $urandom};
		{p1_pin_direction_bit, p1_pin_output_bit, p1_pin_irq_enable_bit,
			p1_pin_irq_edge_select_bit, p1_flag_wdata, p2_pin_direction_bit, p2_pin_output_bit,
			p2_pin_irq_enable_bit, p2_pin_irq_edge_select_bit, p2_flag_wdata, ext_drive,
			ext_level} = r[93:0];
		{timer_compare_out_1, timer_compare_out_2, supervisor_flag_output, aux_clock_out,
			serial_master_out_line_o, serial_slave_out_line_o, serial_clock_line_o,
			uart_transmit_line, master_out_dir_control, slave_out_dir_control,
			serial_clock_dir_control} = r[104:94];
		p1_flag_write = r[107:105] == 3'h0;
		p2_flag_write = r[110:108] == 3'h0;
	endtask : rand_inputs

	task automatic drive_cycle();
		@(posedge sys_clk);
		#1;
		rand_inputs();
	endtask : drive_cycle

	// Phase sets selects, LCD thresholds, buffer and supervisor level
	task automatic set_phase(input int ph);
		p1_peripheral_select_bit = (ph == 0) ? 6'h00 : (ph == 1) ? 6'h3F : 6'($urandom);
		p2_peripheral_select_bit = (ph == 0) ? 8'h00 : (ph == 1) ? 8'hFF : 8'($urandom);
		input_buffer_disable_bit = (ph < 2) ? 4'h0 : 4'($urandom);
		voltage_level_select = (ph == 5 || ph == 9) ? 4'hF : 4'($urandom % 15);
		lcd_corrected_thresholds = ph[2];
		lcd_mode_field = mtab[ph % 4];
		lcd_port_segment_select = ptab[ph % 4];
	endtask : set_phase

	task automatic print_verdict();
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Main sequence, with a reset in the middle of traffic
	initial begin
		live = 1'h0;
		nrst = 1'h0;
		seed = $urandom(58);
		set_phase(0);
		rand_inputs();
		repeat (10) @(posedge sys_clk);
		#1 nrst = 1'h1;
		for (int ph = 0; ph < 12; ph++) begin
			set_phase(ph);
			repeat (40) drive_cycle();
			if (ph == 6) begin
				nrst = 1'h0;
				repeat (2) drive_cycle();
				nrst = 1'h1;
			end
		end
		print_verdict();
	end

	// Watchdog, about ten times the expected run
	initial begin
		#50000;
		err_total++;
		print_verdict();
	end
endmodule : tb
